/* File: inc/usbgc_pkg.sv */
package usbgc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_ADDR       = 8'hbc;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam int         BIT_ENABLE     = 7;
	localparam int         BIT_CLK_SUSP   = 6;
	localparam int         BIT_WAKE_REQ   = 5;
	localparam int         BIT_DETACH     = 4;
	localparam int         BIT_RSM_ACTIVE = 3;
	localparam int         BIT_WAKE_PERM  = 2;
	localparam int         BIT_CONFIG     = 1;
	localparam int         BIT_ADDR_EN    = 0;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 10_000_000;
	localparam int SUSP_MIN_US     = 5000;
	localparam int SUSP_MIN_CYC    = (SUSP_MIN_US * (CLK_HZ / 1_000_000));
	localparam int SE0_MIN_NS      = 2700;
	localparam int SE0_MIN_CYC     = (SE0_MIN_NS * (CLK_HZ / 1_000_000)
		+ 999) / 1000;
	localparam int RESUME_US       = 1000;
	localparam int RESUME_CYC      = RESUME_US * (CLK_HZ / 1_000_000);
	localparam int CNT_W           = 16;
	typedef enum logic [1:0] {USBGC_IDLE, USBGC_SEND} usbgc_rsm_t;
endpackage : usbgc_pkg

/* File: inc/usbgc_if.sv */
interface usbgc_if;
	logic line_se0;
	logic line_idle;
	logic bus_reset;
	logic suspended;
	modport timer (input line_se0, input line_idle,
		output bus_reset, output suspended);
	modport ctrl (output line_se0, output line_idle,
		input bus_reset, input suspended);
endinterface : usbgc_if

/* File: hw/usbgc_linemon.sv */
module usbgc_linemon (
	input  wire logic mclk_in,
	input  wire logic rstn_in,
	usbgc_if.timer    mon
);
	typedef struct packed {
		logic [15:0] se0_cnt;
		logic [15:0] idle_cnt;
		logic        bus_reset;
		logic        suspended;
	} usbgc_mon_t;
	usbgc_mon_t st, next_st;

	// ----------------------------------------------------------------
	// se0 and idle duration counters
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.bus_reset = 1'b0;
		if (mon.line_se0) begin
			if (st.se0_cnt != 16'(usbgc_pkg::SE0_MIN_CYC))
				next_st.se0_cnt = st.se0_cnt + 16'h0001;
			// one pulse when se0 reaches 32 bit times
			if (st.se0_cnt == 16'(usbgc_pkg::SE0_MIN_CYC - 1))
				next_st.bus_reset = 1'b1; // RL10
		end else begin
			next_st.se0_cnt = 16'h0000;
		end
		if (mon.line_idle) begin
			if (st.idle_cnt != 16'(usbgc_pkg::SUSP_MIN_CYC))
				next_st.idle_cnt = st.idle_cnt + 16'h0001;
		end else begin
			next_st.idle_cnt = 16'h0000;
		end
		// long idle qualifies a remote wake
		next_st.suspended =
			(next_st.idle_cnt == 16'(usbgc_pkg::SUSP_MIN_CYC)); // RL3
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in)
			st <= '0;
		else
			st <= next_st;
	end

	assign mon.bus_reset = st.bus_reset;
	assign mon.suspended = st.suspended;
endmodule : usbgc_linemon

/* File: hw/usbgc_ctrl.sv */
// Operation
// RL1 - clock-suspend bit one gates 48MHz clock input; resume detect stays alive
// RL2 - writing one to wake request raises internal wake event
// RL3 - resume sent only with permit, clocks on, and 5 ms suspend
// RL4 - firmware clears wake request; hardware never does
// RL5 - detach one floats the pull-up reference output
// RL6 - detach zero drives the pull-up reference output
// RL7 - firmware sets configured flag after nonzero set-configuration
// RL8 - firmware clears configured flag on zero set-configuration
// RL9 - hardware clears configured flag on reset or bus reset
// RL10 - bus reset detected after SE0 for 32 bit times
// RL11 - resume-active flag set while resume sent, cleared when done
// RL12 - firmware sets wake permit only after host enables it
// RL13 - firmware keeps pull-up floating over 3 us before reattach
// RL14 - clearing enable resets controller and transceiver
// RL15 - address-enable cleared on reset or bus reset; gates address match
module usbgc_ctrl (
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	input  wire logic       line_se0_in,
	input  wire logic       line_idle_in,
	output logic      [7:0] sfr_rdata_out,
	output logic            sfr_sel_out,
	output logic            usb_clk_gate_out,
	output logic            ctrl_reset_n_out,
	output logic            wake_event_out,
	output logic            resume_drive_out,
	output logic            pullup_ref_out,
	output logic            pullup_ref_oe_n_out,
	output logic            addr_match_en_out,
	output logic            configured_out
);
	typedef struct packed {
		logic [1:0]  se0_sync;
		logic [1:0]  idle_sync;
		logic [7:0]  ctl;
		logic        wake_seen;
		usbgc_pkg::usbgc_rsm_t rsm;
		logic [15:0] rsm_cnt;
	} usbgc_st_t;
	usbgc_st_t st, next_st;
	usbgc_if   lm ();
	logic      wr_hit;
	logic      wake_edge;

	// ----------------------------------------------------------------
	// line condition timers
	// ----------------------------------------------------------------
	assign lm.line_se0  = st.se0_sync[1];
	assign lm.line_idle = st.idle_sync[1];
	usbgc_linemon u_mon (
		.mclk_in (mclk_in),
		.rstn_in (rstn_in),
		.mon     (lm)
	);

	// ----------------------------------------------------------------
	// register and resume sequencing
	// ----------------------------------------------------------------
	assign wr_hit = sfr_wr_in && (sfr_addr_in == usbgc_pkg::REG_ADDR);
	// rising write of the wake request is the event
	assign wake_edge = st.ctl[usbgc_pkg::BIT_WAKE_REQ] && !st.wake_seen;

	always_comb begin
		next_st = st;
		next_st.se0_sync  = {st.se0_sync[0], line_se0_in};
		next_st.idle_sync = {st.idle_sync[0], line_idle_in};
		if (wr_hit) begin
			// resume-active bit is hardware owned; keep it
			next_st.ctl = (sfr_wdata_in & ~(8'h01 << usbgc_pkg::BIT_RSM_ACTIVE))
				| (st.ctl & (8'h01 << usbgc_pkg::BIT_RSM_ACTIVE));
		end
		// request bit stays until firmware writes zero
		next_st.wake_seen = st.ctl[usbgc_pkg::BIT_WAKE_REQ]; // RL4
		case (st.rsm)
			usbgc_pkg::USBGC_IDLE: begin
				if (wake_edge && st.ctl[usbgc_pkg::BIT_WAKE_PERM]
					&& !st.ctl[usbgc_pkg::BIT_CLK_SUSP]
					&& st.ctl[usbgc_pkg::BIT_ENABLE]
					&& lm.suspended) begin // RL3
					next_st.rsm = usbgc_pkg::USBGC_SEND;
					next_st.rsm_cnt = 16'h0000;
					next_st.ctl[usbgc_pkg::BIT_RSM_ACTIVE] = 1'b1; // RL11
				end
			end
			usbgc_pkg::USBGC_SEND: begin
				next_st.rsm_cnt = st.rsm_cnt + 16'h0001;
				if (st.rsm_cnt == 16'(usbgc_pkg::RESUME_CYC - 1)) begin
					next_st.rsm = usbgc_pkg::USBGC_IDLE;
					next_st.ctl[usbgc_pkg::BIT_RSM_ACTIVE] = 1'b0; // RL11
				end
			end
			default: next_st.rsm = usbgc_pkg::USBGC_IDLE;
		endcase
		// bus reset wins over a simultaneous firmware set
		if (lm.bus_reset) begin
			next_st.ctl[usbgc_pkg::BIT_CONFIG]  = 1'b0; // RL9
			next_st.ctl[usbgc_pkg::BIT_ADDR_EN] = 1'b0; // RL15
		end
		// disabled controller aborts any resume in flight
		if (!next_st.ctl[usbgc_pkg::BIT_ENABLE]) begin
			next_st.rsm = usbgc_pkg::USBGC_IDLE; // RL14
			next_st.ctl[usbgc_pkg::BIT_RSM_ACTIVE] = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in)
			st <= '{ctl: usbgc_pkg::REG_RESET, rsm: usbgc_pkg::USBGC_IDLE,
				default: '0}; // RL9
		else
			st <= next_st;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign sfr_sel_out = sfr_rd_in && (sfr_addr_in == usbgc_pkg::REG_ADDR);
	assign sfr_rdata_out = st.ctl;
	assign usb_clk_gate_out = !st.ctl[usbgc_pkg::BIT_CLK_SUSP]; // RL1
	assign ctrl_reset_n_out = st.ctl[usbgc_pkg::BIT_ENABLE]; // RL14
	assign wake_event_out = wake_edge; // RL2
	assign resume_drive_out = (st.rsm == usbgc_pkg::USBGC_SEND);
	assign pullup_ref_out = 1'b1; // RL6
	// float the reference for a simulated detach
	assign pullup_ref_oe_n_out = st.ctl[usbgc_pkg::BIT_DETACH]; // RL5
	assign addr_match_en_out = st.ctl[usbgc_pkg::BIT_ADDR_EN]; // RL15
	assign configured_out = st.ctl[usbgc_pkg::BIT_CONFIG];
endmodule : usbgc_ctrl

/* File: sim/usbgc_sva.sv */
module usbgc_sva (
	input wire logic       mclk_in,
	input wire logic       rstn_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic       sfr_wr_in,
	input wire logic       line_se0_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       usb_clk_gate_out,
	input wire logic       ctrl_reset_n_out,
	input wire logic       wake_event_out,
	input wire logic       resume_drive_out,
	input wire logic       pullup_ref_out,
	input wire logic       pullup_ref_oe_n_out,
	input wire logic       addr_match_en_out,
	input wire logic       configured_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	logic [5:0] se0_cnt;
	logic       hit;
	assign hit = sfr_wr_in && sfr_addr_in == 8'hbc;
	// se0 run length, saturating so one long reset is seen once
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in)
			se0_cnt <= 6'h00;
		else
			se0_cnt <= line_se0_in ? se0_cnt + {5'h00, ~&se0_cnt} : 6'h00;
	end
	clk_gate_a: assert property (hit |=>
		usb_clk_gate_out == !$past(sfr_wdata_in[6])) else $error("gate");
	ctl_reset_a: assert property (hit |=>
		ctrl_reset_n_out == $past(sfr_wdata_in[7])) else $error("enable");
	pullup_float_a: assert property (hit |=>
		pullup_ref_oe_n_out == $past(sfr_wdata_in[4])) else $error("detach");
	pullup_drive_a: assert property (!pullup_ref_oe_n_out |->
		pullup_ref_out) else $error("pullup level");
	wake_pulse_a: assert property ($rose(sfr_rdata_out[5]) |->
		wake_event_out ##1 !wake_event_out) else $error("wake pulse");
	resume_gate_a: assert property ($rose(resume_drive_out) |->
		sfr_rdata_out[2] && usb_clk_gate_out) else $error("resume gate");
	resume_flag_a: assert property (
		resume_drive_out == sfr_rdata_out[3]) else $error("resume flag");
	bus_reset_a: assert property (se0_cnt == 6'd32 |->
		!configured_out && !addr_match_en_out) else $error("bus reset");
endmodule : usbgc_sva

bind usbgc_ctrl usbgc_sva sva (.*);

/* File: sim/usbgc_host.sv */
module usbgc_host (
	input  wire logic [1:0] mode_in,
	output logic            se0_out,
	output logic            idle_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// 0 traffic, 1 suspend idle, 2 bus reset
	assign se0_out  = mode_in == 2'h2;
	assign idle_out = mode_in == 2'h1;
endmodule : usbgc_host

/* File: sim/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk_in, rstn_in, sfr_wr_in, sfr_rd_in, line_se0_in;
	logic       line_idle_in, sfr_sel_out, usb_clk_gate_out, wake_event_out;
	logic       ctrl_reset_n_out, resume_drive_out, pullup_ref_out;
	logic       pullup_ref_oe_n_out, addr_match_en_out, configured_out;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, d, pins;
	logic [1:0] mode;
	int         err_total, n_compared, seed, cyc;
	usbgc_ctrl dut (.*);
	usbgc_host host (.mode_in(mode), .se0_out(line_se0_in),
		.idle_out(line_idle_in));
	assign pins = {2'h0, usb_clk_gate_out, ctrl_reset_n_out,
		pullup_ref_oe_n_out, configured_out, addr_match_en_out, pullup_ref_out};
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		sfr_addr_in  = a;
		sfr_wdata_in = v;
		sfr_wr_in    = 1'b1;
		@(negedge mclk_in) sfr_wr_in = 1'b0;
		// one idle cycle so back-to-back calls never re-raise in one step
		@(negedge mclk_in);
	endtask : wr_reg
	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : wait_n
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// pin image expected from a written byte
	function automatic logic [7:0] outs(input logic [7:0] v);
		return {2'h0, ~v[6], v[7], v[4], v[1], v[0], 1'b1};
	endfunction : outs
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	// hang guard well above the ~60k cycles of the sequence
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			results();
		end
	end
	initial begin
		{rstn_in, sfr_wr_in, sfr_addr_in, sfr_wdata_in, mode} = '0;
		sfr_rd_in = 1'b1;
		seed = 31608;
		wait_n(3);
		rstn_in = 1'b1;
		chk(sfr_rdata_out, 8'h00);
		chk(pins, 8'h21);
		for (int i = 0; i < 24; i++) begin
			d = $random(seed);
			wr_reg(8'hbc, d);
			chk(sfr_rdata_out, d & 8'hf7);
			chk({7'h0, sfr_sel_out}, 8'h01);
			chk(pins, outs(d));
			wr_reg(8'hbd, ~d);
			chk(sfr_rdata_out, d & 8'hf7);
			chk({7'h0, sfr_sel_out}, 8'h00);
		end
		// detach held well over 3 us before reattach
		wr_reg(8'hbc, 8'h90);
		wait_n(40);
		chk(pins, outs(8'h90));
		wr_reg(8'hbc, 8'h80);
		chk(pins, outs(8'h80));
		wr_reg(8'hbc, 8'h83);
		mode = 2'h2;
		wait_n(20);
		mode = 2'h0;
		wait_n(4);
		chk(sfr_rdata_out, 8'h83);
		mode = 2'h2;
		wait_n(40);
		mode = 2'h0;
		wait_n(4);
		chk(sfr_rdata_out, 8'h80);
		mode = 2'h1;
		wait_n(50100);
		wr_reg(8'hbc, 8'ha0);
		wait_n(4);
		chk({7'h0, resume_drive_out}, 8'h00);
		wr_reg(8'hbc, 8'h80);
		wr_reg(8'hbc, 8'ha4);
		wait_n(4);
		chk(sfr_rdata_out, 8'hac);
		wait_n(10010);
		chk(sfr_rdata_out, 8'ha4);
		results();
	end
endmodule : tb
